/* File: pkg/scc_pkg.sv */
// constants, types and decode helpers shared by the reference capture block
package scc_pkg;

	// register port geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 12'h120;
	localparam logic [ADDR_W-1:0] ADDR_IGNORE   = 12'h121;
	localparam logic [ADDR_W-1:0] ADDR_WINDOW   = 12'h122;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS    = 12'h124;
	localparam logic [ADDR_W-1:0] ADDR_INT_STS  = 12'h125;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 12'h126;

	// capture configuration fields
	localparam int CFG_FLAG_RST_BIT  = 6;
	localparam int CFG_TRANS_SEL_BIT = 4;
	localparam int CFG_EDGE_SEL_BIT  = 3;
	localparam int CFG_MODE_HI       = 2;
	localparam int CFG_MODE_LO       = 1;
	localparam logic [DATA_W-1:0] CFG_RESV_MASK = 8'ha1;

	// ignore count and skew window fields
	localparam int IGN_HI     = 3;
	localparam int IGN_LO     = 0;
	localparam int WIN_NEG_HI = 3;
	localparam int WIN_NEG_LO = 2;
	localparam int WIN_POS_HI = 1;
	localparam int WIN_POS_LO = 0;
	localparam logic [DATA_W-1:0] NIB_RESV_MASK = 8'hf0;

	// reset values
	localparam logic [DATA_W-1:0] CONFIG_RST = 8'h00;
	localparam logic [DATA_W-1:0] IGNORE_RST = 8'h00;
	localparam logic [DATA_W-1:0] WINDOW_RST = 8'h00;

	// mode field encodings
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_CONT  = 2'h1;
	localparam logic [1:0] MODE_NSHOT = 2'h2;

	// flag register bits
	localparam int FLG_SETUP_BIT   = 0;
	localparam int FLG_HOLD_BIT    = 1;
	localparam int FLG_ALIGNED_BIT = 2;

	// interrupt status and mask bits
	localparam int INT_W       = 3;
	localparam int INT_CAPTURE = 0;
	localparam int INT_SETUP   = 1;
	localparam int INT_HOLD    = 2;

	// local frame phase counter, one step per sample clock
	localparam int PHASE_W = 4;
	localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;
	localparam logic [PHASE_W-1:0] PHASE_ONE  = 4'h1;
	localparam logic [PHASE_W-1:0] PHASE_HALF = 4'h8;

	// capture sequencer states
	typedef enum logic [3:0] {
		SCC_OFF   = 4'h1,
		SCC_CONT  = 4'h2,
		SCC_ARMED = 4'h4,
		SCC_DONE  = 4'h8
	} scc_state_t;

	// state that a freshly written mode field starts from
	function automatic scc_state_t scc_mode_state(input logic [1:0] mode);
		case (mode)
			MODE_CONT:  scc_mode_state = SCC_CONT;
			MODE_NSHOT: scc_mode_state = SCC_ARMED;
			default:    scc_mode_state = SCC_OFF;
		endcase
	endfunction

endpackage

/* File: hw/scc_transition.sv */
// detects the selected direction of transition on the sampled reference level
`timescale 1ns/1ns
module scc_transition (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic level_i,
	input  wire logic falling_sel_i,
	output logic      valid_o
);

	typedef struct packed {
		logic prev;
		logic valid;
	} scc_tr_state_t;

	scc_tr_state_t st;
	scc_tr_state_t next_st;

	// one-cycle pulse for a transition of the chosen polarity
	always_comb begin
		next_st.prev  = level_i;
		next_st.valid = 1'b0;
		if (!rst_i && (level_i != st.prev)) begin
			next_st.valid = falling_sel_i ? st.prev : level_i;
		end
	end

	// prev keeps tracking the level under reset so no false edge follows release
	always_ff @(posedge clock_i) begin
		st <= next_st;
	end

	assign valid_o = st.valid;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_rise_valid;
		(!falling_sel_i && $rose(level_i)) |=> valid_o;
	endproperty
	a_rise_valid: assert property (p_rise_valid) else $error("rising transition not flagged");

	property p_fall_valid;
		(falling_sel_i && $fell(level_i)) |=> valid_o;
	endproperty
	a_fall_valid: assert property (p_fall_valid) else $error("falling transition not flagged");

	property p_no_wrong_dir;
		((falling_sel_i && $rose(level_i)) || (!falling_sel_i && $fell(level_i))) |=> !valid_o;
	endproperty
	a_no_wrong_dir: assert property (p_no_wrong_dir) else $error("wrong transition flagged");

endmodule // scc_transition

/* File: hw/scc_capture.sv */
// reference capture control: registers, mode sequencer, skew window check
// Functional notes
// - flag reset bit holds error flags cleared
// - bit4 zero: rising reference transitions valid
// - bit4 one: falling reference transitions valid
// - bit3 picks rising or falling clock sample
// - mode field: disabled, continuous, N-shot
// - N-shot skips programmed count of transitions first
// - negative window tolerates zero to three clocks
// - positive window tolerates zero to three clocks
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module scc_capture (
	input  wire logic                        clock_i,
	input  wire logic                        rst_i,
	input  wire logic [scc_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [scc_pkg::DATA_W-1:0]  wr_data_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	input  wire logic                        sysref_rise_i,
	input  wire logic                        sysref_fall_i,
	output logic      [scc_pkg::DATA_W-1:0]  rd_data_o,
	output logic                             irq_o,
	output logic                             capture_o,
	output logic                             aligned_o,
	output logic                             setup_err_o,
	output logic                             hold_err_o
);

	typedef struct packed {
		logic                        flag_rst;
		logic                        trans_sel;
		logic                        edge_sel;
		logic [1:0]                  mode;
		logic [3:0]                  ign;
		logic [1:0]                  win_neg;
		logic [1:0]                  win_pos;
		scc_pkg::scc_state_t         seq;
		logic [3:0]                  skip_cnt;
		logic [scc_pkg::PHASE_W-1:0] phase;
		logic                        aligned;
		logic                        setup_err;
		logic                        hold_err;
		logic [scc_pkg::INT_W-1:0]   int_sts;
		logic [scc_pkg::INT_W-1:0]   int_mask;
		logic [scc_pkg::DATA_W-1:0]  rd_data;
		logic                        capture;
		logic                        irq;
	} scc_state_all_t;

	scc_state_all_t st;
	scc_state_all_t next_st;

	logic                        sel_level;
	logic                        tr_valid;
	logic                        acting;
	logic                        accept;
	logic [scc_pkg::PHASE_W-1:0] early_dist;
	logic                        late_ok;
	logic                        early_ok;
	logic                        late_bad;
	logic                        early_bad;
	logic [scc_pkg::INT_W-1:0]   events;
	logic [scc_pkg::DATA_W-1:0]  rd_mux;

	// sample the reference on the chosen clock edge
	assign sel_level = st.edge_sel ? sysref_fall_i : sysref_rise_i;

	scc_transition u_transition (
		.clock_i       (clock_i),
		.rst_i         (rst_i),
		.level_i       (sel_level),
		.falling_sel_i (st.trans_sel),
		.valid_o       (tr_valid)
	);

	// a valid transition counts only while the sequencer is listening
	assign acting = tr_valid && ((st.seq == scc_pkg::SCC_CONT) || (st.seq == scc_pkg::SCC_ARMED));
	assign accept = acting && !((st.seq == scc_pkg::SCC_ARMED) && (st.skip_cnt != 4'h0));

	// skew classification against the local frame phase
	assign early_dist = scc_pkg::PHASE_ZERO - st.phase;
	assign late_ok    = (st.phase != scc_pkg::PHASE_ZERO) && (st.phase <= {2'h0, st.win_pos});
	assign early_ok   = (st.phase != scc_pkg::PHASE_ZERO) && (early_dist <= {2'h0, st.win_neg});
	assign late_bad   = !late_ok && (st.phase != scc_pkg::PHASE_ZERO) && (st.phase < scc_pkg::PHASE_HALF);
	assign early_bad  = !early_ok && (st.phase >= scc_pkg::PHASE_HALF);

	// read mux; reserved bits come back as zero
	always_comb begin
		rd_mux = '0;
		case (addr_i)
			scc_pkg::ADDR_CONFIG: begin
				rd_mux[scc_pkg::CFG_FLAG_RST_BIT]                  = st.flag_rst;
				rd_mux[scc_pkg::CFG_TRANS_SEL_BIT]                 = st.trans_sel;
				rd_mux[scc_pkg::CFG_EDGE_SEL_BIT]                  = st.edge_sel;
				rd_mux[scc_pkg::CFG_MODE_HI:scc_pkg::CFG_MODE_LO]  = st.mode;
			end
			scc_pkg::ADDR_IGNORE: begin
				rd_mux[scc_pkg::IGN_HI:scc_pkg::IGN_LO] = st.ign;
			end
			scc_pkg::ADDR_WINDOW: begin
				rd_mux[scc_pkg::WIN_NEG_HI:scc_pkg::WIN_NEG_LO] = st.win_neg;
				rd_mux[scc_pkg::WIN_POS_HI:scc_pkg::WIN_POS_LO] = st.win_pos;
			end
			scc_pkg::ADDR_FLAGS: begin
				rd_mux[scc_pkg::FLG_SETUP_BIT]   = st.setup_err;
				rd_mux[scc_pkg::FLG_HOLD_BIT]    = st.hold_err;
				rd_mux[scc_pkg::FLG_ALIGNED_BIT] = st.aligned;
			end
			scc_pkg::ADDR_INT_STS: begin
				rd_mux[scc_pkg::INT_W-1:0] = st.int_sts;
			end
			scc_pkg::ADDR_INT_MASK: begin
				rd_mux[scc_pkg::INT_W-1:0] = st.int_mask;
			end
			default: begin
				rd_mux = '0; // unmapped reads return zero
			end
		endcase
	end

	// next state of the whole block
	always_comb begin
		next_st         = st;
		next_st.capture = 1'b0;
		next_st.rd_data = '0;
		events          = '0;

		// free-running frame phase once aligned
		if (st.aligned) begin
			next_st.phase = st.phase + scc_pkg::PHASE_ONE;
		end

		// transition handling
		if (acting && !accept) begin
			next_st.skip_cnt = st.skip_cnt - 4'h1;
		end
		if (accept) begin
			next_st.capture           = 1'b1;
			events[scc_pkg::INT_CAPTURE] = 1'b1;
			if (st.seq == scc_pkg::SCC_ARMED) begin
				next_st.seq = scc_pkg::SCC_DONE;
			end
			if (!st.aligned || late_bad || early_bad) begin
				next_st.aligned = 1'b1;
				next_st.phase   = scc_pkg::PHASE_ONE;
			end
			if (st.aligned && late_bad && !st.flag_rst) begin
				next_st.hold_err          = 1'b1;
				events[scc_pkg::INT_HOLD] = 1'b1;
			end
			if (st.aligned && early_bad && !st.flag_rst) begin
				next_st.setup_err          = 1'b1;
				events[scc_pkg::INT_SETUP] = 1'b1;
			end
		end
		if (st.flag_rst) begin
			next_st.setup_err = 1'b0;
			next_st.hold_err  = 1'b0;
		end

		// register writes; reserved bits are dropped
		if (wr_i) begin
			case (addr_i)
				scc_pkg::ADDR_CONFIG: begin
					next_st.flag_rst  = wr_data_i[scc_pkg::CFG_FLAG_RST_BIT];
					next_st.trans_sel = wr_data_i[scc_pkg::CFG_TRANS_SEL_BIT];
					next_st.edge_sel  = wr_data_i[scc_pkg::CFG_EDGE_SEL_BIT];
					next_st.mode      = wr_data_i[scc_pkg::CFG_MODE_HI:scc_pkg::CFG_MODE_LO];
					next_st.seq       = scc_pkg::scc_mode_state(
						wr_data_i[scc_pkg::CFG_MODE_HI:scc_pkg::CFG_MODE_LO]);
					next_st.skip_cnt  = st.ign;
				end
				scc_pkg::ADDR_IGNORE: begin
					next_st.ign = wr_data_i[scc_pkg::IGN_HI:scc_pkg::IGN_LO];
				end
				scc_pkg::ADDR_WINDOW: begin
					next_st.win_neg = wr_data_i[scc_pkg::WIN_NEG_HI:scc_pkg::WIN_NEG_LO];
					next_st.win_pos = wr_data_i[scc_pkg::WIN_POS_HI:scc_pkg::WIN_POS_LO];
				end
				scc_pkg::ADDR_INT_MASK: begin
					next_st.int_mask = wr_data_i[scc_pkg::INT_W-1:0];
				end
				default: begin
					next_st.int_mask = st.int_mask; // other addresses store nothing
				end
			endcase
		end

		// sticky interrupt status: a new event beats a write-one clear
		if (wr_i && (addr_i == scc_pkg::ADDR_INT_STS)) begin
			next_st.int_sts = (st.int_sts & ~wr_data_i[scc_pkg::INT_W-1:0]) | events;
		end else begin
			next_st.int_sts = st.int_sts | events;
		end
		next_st.irq = |(next_st.int_sts & next_st.int_mask);

		if (rd_i) begin
			next_st.rd_data = rd_mux;
		end
	end

	// single register stage for all state, synchronous reset
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st.flag_rst  <= scc_pkg::CONFIG_RST[scc_pkg::CFG_FLAG_RST_BIT];
			st.trans_sel <= scc_pkg::CONFIG_RST[scc_pkg::CFG_TRANS_SEL_BIT];
			st.edge_sel  <= scc_pkg::CONFIG_RST[scc_pkg::CFG_EDGE_SEL_BIT];
			st.mode      <= scc_pkg::CONFIG_RST[scc_pkg::CFG_MODE_HI:scc_pkg::CFG_MODE_LO];
			st.ign       <= scc_pkg::IGNORE_RST[scc_pkg::IGN_HI:scc_pkg::IGN_LO];
			st.win_neg   <= scc_pkg::WINDOW_RST[scc_pkg::WIN_NEG_HI:scc_pkg::WIN_NEG_LO];
			st.win_pos   <= scc_pkg::WINDOW_RST[scc_pkg::WIN_POS_HI:scc_pkg::WIN_POS_LO];
			st.seq       <= scc_pkg::SCC_OFF;
			st.skip_cnt  <= '0;
			st.phase     <= scc_pkg::PHASE_ZERO;
			st.aligned   <= 1'b0;
			st.setup_err <= 1'b0;
			st.hold_err  <= 1'b0;
			st.int_sts   <= '0;
			st.int_mask  <= '0;
			st.rd_data   <= '0;
			st.capture   <= 1'b0;
			st.irq       <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign rd_data_o   = st.rd_data;
	assign irq_o       = st.irq;
	assign capture_o   = st.capture;
	assign aligned_o   = st.aligned;
	assign setup_err_o = st.setup_err;
	assign hold_err_o  = st.hold_err;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// helper: accepted transition with a known frame phase
	logic chk_aligned_acc;
	assign chk_aligned_acc = accept && st.aligned && !st.flag_rst;

	property p_flag_hold;
		st.flag_rst |=> (!setup_err_o && !hold_err_o);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("error flags set during flag reset");

	property p_edge_sel;
		(st.seq == scc_pkg::SCC_CONT && !st.trans_sel && !wr_i && $rose(sysref_rise_i) && !st.edge_sel
			&& !$past(st.edge_sel))
			##1 (!wr_i) |=> capture_o;
	endproperty
	a_edge_sel: assert property (p_edge_sel) else $error("rising-edge sample not captured");

	property p_mode_load;
		(wr_i && addr_i == scc_pkg::ADDR_CONFIG)
			|=> (st.seq == scc_pkg::scc_mode_state($past(wr_data_i[scc_pkg::CFG_MODE_HI:scc_pkg::CFG_MODE_LO])));
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode write did not set sequencer");

	property p_off_quiet;
		(st.seq == scc_pkg::SCC_OFF && !wr_i) [*2] |=> !capture_o;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("capture while disabled");

	property p_skip;
		(tr_valid && st.seq == scc_pkg::SCC_ARMED && st.skip_cnt != 4'h0 && !wr_i)
			|=> (!capture_o && st.skip_cnt == $past(st.skip_cnt) - 4'h1);
	endproperty
	a_skip: assert property (p_skip) else $error("ignored transition was captured");

	sequence s_shot;
		tr_valid && st.seq == scc_pkg::SCC_ARMED && st.skip_cnt == 4'h0 && !wr_i;
	endsequence
	property p_one_shot;
		s_shot |=> (capture_o && st.seq == scc_pkg::SCC_DONE) ##1 (!capture_o);
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("n-shot capture wrong");

	property p_cont;
		(tr_valid && st.seq == scc_pkg::SCC_CONT) |=> capture_o;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous transition missed");

	property p_neg_ok;
		(chk_aligned_acc && early_ok) |=> $stable(setup_err_o) && (st.phase == $past(st.phase) + scc_pkg::PHASE_ONE);
	endproperty
	a_neg_ok: assert property (p_neg_ok) else $error("tolerated early transition flagged");

	property p_neg_bad;
		(chk_aligned_acc && early_bad) |=> setup_err_o && st.phase == scc_pkg::PHASE_ONE;
	endproperty
	a_neg_bad: assert property (p_neg_bad) else $error("early transition not flagged");

	property p_pos_ok;
		(chk_aligned_acc && late_ok) |=> $stable(hold_err_o);
	endproperty
	a_pos_ok: assert property (p_pos_ok) else $error("tolerated late transition flagged");

	property p_pos_bad;
		(chk_aligned_acc && late_bad) |=> hold_err_o && st.phase == scc_pkg::PHASE_ONE;
	endproperty
	a_pos_bad: assert property (p_pos_bad) else $error("late transition not flagged");

	property p_resv;
		(rd_i && addr_i == scc_pkg::ADDR_CONFIG) |=> ((rd_data_o & scc_pkg::CFG_RESV_MASK) == 8'h00);
	endproperty
	a_resv: assert property (p_resv) else $error("reserved config bits not zero");

	property p_resv_nib;
		(rd_i && (addr_i == scc_pkg::ADDR_IGNORE || addr_i == scc_pkg::ADDR_WINDOW))
			|=> ((rd_data_o & scc_pkg::NIB_RESV_MASK) == 8'h00);
	endproperty
	a_resv_nib: assert property (p_resv_nib) else $error("reserved upper bits not zero");

endmodule // scc_capture

/* File: testbench/scc_ref_src.sv */
// behavioural reference timing source: one level, seen at both clock edges
`timescale 1ns/1ns
module scc_ref_src (
	input  wire logic clock_i,
	input  wire logic toggle_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic ref_lvl = 1'b0;

	// level flips shortly after the edge that sees a request
	always @(posedge clock_i) begin
		if (toggle_i) begin
			ref_lvl <= #2 ~ref_lvl;
		end
	end

	// sampled copies, so falling-edge sampling sees a change half a cycle sooner
	initial begin
		rise_o = 1'b0;
		fall_o = 1'b0;
	end
	always @(posedge clock_i) rise_o <= ref_lvl;
	always @(negedge clock_i) fall_o <= ref_lvl;
endmodule // scc_ref_src

/* File: testbench/scc_capture_tb.sv */
// self-checking bench for the reference capture control block
`timescale 1ns/1ns
module scc_capture_tb;
	logic                       clock_i = 1'b0;
	logic                       rst_i = 1'b1;
	logic [scc_pkg::ADDR_W-1:0] addr_i = '0;
	logic [scc_pkg::DATA_W-1:0] wr_data_i = '0;
	logic                       wr_i = 1'b0;
	logic                       rd_i = 1'b0;
	logic                       toggle = 1'b0;
	logic                       sysref_rise;
	logic                       sysref_fall;
	logic [scc_pkg::DATA_W-1:0] rd_data_o;
	logic                       irq_o;
	logic                       capture_o;
	logic                       aligned_o;
	logic                       setup_err_o;
	logic                       hold_err_o;
	logic [scc_pkg::DATA_W-1:0] rd_q[$];
	int                         cap_q[$];
	int                         cyc = 0;
	int                         n_errors = 0;
	int                         n_checks = 0;
	int                         seed = 59;
	int                         lat = 5;
	int                         t0;
	bit                         lvl = 1'b0;
	bit                         fsel = 1'b0;
	bit                         rd_d = 1'b0;
	logic [scc_pkg::DATA_W-1:0] rv;
	logic [scc_pkg::DATA_W-1:0] cfg_prev = '0;
	logic [scc_pkg::ADDR_W-1:0] adr[4] = '{12'h120, 12'h121, 12'h122, 12'h123};
	logic [scc_pkg::DATA_W-1:0] msk[3] = '{8'h5e, 8'h0f, 8'h0f};
	logic [3:0]                 ign[3] = '{4'h0, 4'h1, 4'hf};

	// free-running sample clock
	initial begin
		forever #5 clock_i = ~clock_i;
	end

	scc_capture scc_capture_i (
		.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.sysref_rise_i(sysref_rise), .sysref_fall_i(sysref_fall), .rd_data_o(rd_data_o), .irq_o(irq_o),
		.capture_o(capture_o), .aligned_o(aligned_o), .setup_err_o(setup_err_o), .hold_err_o(hold_err_o)
	);

	scc_ref_src scc_ref_src_i (.clock_i(clock_i), .toggle_i(toggle), .rise_o(sysref_rise), .fall_o(sysref_fall));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		check("capture_missing", cap_q.size(), 0);
		if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [scc_pkg::ADDR_W-1:0] a, input logic [scc_pkg::DATA_W-1:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// read strobe; the watcher compares the data a cycle later
	task automatic rd(input logic [scc_pkg::ADDR_W-1:0] a, input logic [scc_pkg::DATA_W-1:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		rd_q.push_back(e);
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask

	// ask the source for one level change at launch cycle a
	task automatic tog(input int a);
		do @(posedge clock_i); while (cyc != a);
		toggle <= 1'b1;
		lvl = ~lvl;
		@(posedge clock_i);
		toggle <= 1'b0;
	endtask

	// selected-direction transition whose capture would show in cycle t
	task automatic sref(input int t, input bit exp);
		if (lvl != fsel) tog(t - lat - 4);
		tog(t - lat);
		if (exp) cap_q.push_back(t);
	endtask

	// watcher: read data and capture pulses against the oldest notes
	always @(posedge clock_i) begin
		if (rd_d) check("rd_data", rd_data_o, rd_q.pop_front());
		rd_d = rd_i;
		if (capture_o === 1'b1) begin
			if (cap_q.size() == 0) check("capture_extra", 1, 0);
			else check("capture_cycle", cyc, cap_q.pop_front());
		end
		cyc <= cyc + 1;
	end

	// watchdog against a hang
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		foreach (adr[i]) rd(adr[i], 8'h00);
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 3; i++) begin
				rv = (k == 0) ? 8'hff : 8'($random(seed));
				// disable first, then change the transition select, then enable
				if (i == 0) begin
					wr(adr[0], cfg_prev & 8'hf9);
					wr(adr[0], rv & 8'hf9);
					cfg_prev = rv;
				end
				wr(adr[i], rv);
				rd(adr[i], rv & msk[i]);
			end
		end
		wr(scc_pkg::ADDR_CONFIG, cfg_prev & 8'hf9);
		wr(scc_pkg::ADDR_CONFIG, 8'h00);
		// skew windows: one clock each side, continuous rising capture
		wr(scc_pkg::ADDR_IGNORE, 8'h00);
		wr(scc_pkg::ADDR_WINDOW, 8'h05);
		wr(scc_pkg::ADDR_CONFIG, 8'h02);
		check("aligned_init", aligned_o, 1'b0);
		t0 = cyc + 20;
		sref(t0, 1);
		sref(t0 + 17, 1);
		check("aligned", aligned_o, 1'b1);
		sref(t0 + 31, 1);
		sref(t0 + 50, 1);
		check("hold_none", hold_err_o, 1'b0);
		check("setup_none", setup_err_o, 1'b0);
		sref(t0 + 64, 1);
		check("hold_late", hold_err_o, 1'b1);
		check("setup_early", setup_err_o, 1'b0);
		repeat (6) @(posedge clock_i);
		rd(scc_pkg::ADDR_FLAGS, 8'h07);
		// interrupt: status, mask, write-one clear
		rd(scc_pkg::ADDR_INT_STS, 8'h07);
		check("irq_masked", irq_o, 1'b0);
		wr(scc_pkg::ADDR_INT_MASK, 8'h02);
		@(posedge clock_i);
		check("irq_set", irq_o, 1'b1);
		wr(scc_pkg::ADDR_INT_STS, 8'h02);
		@(posedge clock_i);
		check("irq_clear", irq_o, 1'b0);
		// flag reset holds both error flags cleared
		wr(scc_pkg::ADDR_CONFIG, 8'h42);
		sref(cyc + 23, 1);
		repeat (6) @(posedge clock_i);
		check("setup_held", setup_err_o, 1'b0);
		rd(scc_pkg::ADDR_FLAGS, 8'h04);
		// disabled and unused mode values: no capture
		foreach (msk[i]) begin
			wr(scc_pkg::ADDR_CONFIG, (i == 1) ? 8'h46 : 8'h40);
			sref(cyc + 20, 0);
		end
		// falling transitions, selected while disabled
		wr(scc_pkg::ADDR_CONFIG, 8'h50);
		wr(scc_pkg::ADDR_CONFIG, 8'h52);
		fsel = 1'b1;
		t0 = cyc + 20;
		sref(t0, 1);
		sref(t0 + 16, 1);
		// let the last capture land before the mode is switched off
		repeat (4) @(posedge clock_i);
		// falling clock edge sampling shortens the path by one cycle
		wr(scc_pkg::ADDR_CONFIG, 8'h50);
		wr(scc_pkg::ADDR_CONFIG, 8'h48);
		wr(scc_pkg::ADDR_CONFIG, 8'h4a);
		fsel = 1'b0;
		lat = 4;
		t0 = cyc + 20;
		sref(t0, 1);
		sref(t0 + 16, 1);
		// N-shot: skip the programmed count, capture once, then stay quiet
		lat = 5;
		foreach (ign[j]) begin
			wr(scc_pkg::ADDR_IGNORE, {4'h0, ign[j]});
			wr(scc_pkg::ADDR_CONFIG, 8'h44);
			t0 = cyc + 12;
			for (int i = 0; i <= ign[j] + 1; i++) sref(t0 + 16 * i, i == ign[j]);
		end
		repeat (20) @(posedge clock_i);
		stop_test();
	end
endmodule // scc_capture_tb
